// ==== common/hts_params.svh ====
// Sequencer constants
`ifndef HTS_PARAMS_SVH
`define HTS_PARAMS_SVH

// Register byte offsets
`define HTS_ADDR_CTRL     8'h00
`define HTS_ADDR_TESTTIME 8'h04
`define HTS_ADDR_UCWIN    8'h08
`define HTS_ADDR_STATUS   8'h0C
`define HTS_ADDR_IRQSTAT  8'h10
`define HTS_ADDR_IRQMASK  8'h14
`define HTS_ADDR_ELAPSED  8'h18

// CTRL fields
`define HTS_CTRL_SWRESET  0
`define HTS_CTRL_UCEN     1
`define HTS_CTRL_RST      2'h2

// Timing register resets, ms
`define HTS_TESTTIME_RST  16'h03E8
`define HTS_UCWIN_RST     16'h0064

// STATUS fields
`define HTS_ST_TESTING    0
`define HTS_ST_FAIL       1
`define HTS_ST_GNDOK      2
`define HTS_ST_ARMED      3
`define HTS_ST_CAUSE_LSB  4

// Interrupt bits
`define HTS_IRQ_START     0
`define HTS_IRQ_FAIL      1
`define HTS_IRQ_DONE      2
`define HTS_IRQ_BITS      3

// Input pin indices
`define HTS_IN_START      0
`define HTS_IN_RESET      1
`define HTS_IN_ARC        2
`define HTS_IN_TOTAL      3
`define HTS_IN_GNDBAD     4
`define HTS_IN_ZC         5
`define HTS_IN_CURRENT    6
`define HTS_IN_COUNT      7

// Clock, ms tick, under-current hold
`define HTS_CLK_MHZ       100
`define HTS_TICK_US       1000
`define HTS_HOLD_MS       16'h03E8

// AXI responses
`define HTS_RESP_OKAY     2'h0
`define HTS_RESP_SLVERR   2'h2

`endif

// ==== common/hts_pkg.sv ====
// Types of the hipot test sequencer
package hts_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ARMED,
    SEQ_TEST,
    SEQ_FAIL
  } hts_seq_e;

  typedef logic [15:0] hts_ms_t;
endpackage : hts_pkg

// ==== common/hts_pin_if.sv ====
// Raw pin levels and their synchronised copies
`timescale 1ns/1ps
interface hts_pin_if;
  logic [6:0] rawPins;
  logic [6:0] syncPins;

  modport syncer (input rawPins, output syncPins);
  modport user   (output rawPins, input syncPins);
endinterface : hts_pin_if

// ==== hdl/hts_input_sync.sv ====
// Two-flop synchroniser for the push-button and comparator pins
`timescale 1ns/1ps
`include "hts_params.svh"
module hts_input_sync (
  // Clock and reset
  input wire logic  mclk,
  input wire logic  sys_rst,
  // Pins
  hts_pin_if.syncer pins
);
  logic [`HTS_IN_COUNT-1:0] meta_r;
  logic [`HTS_IN_COUNT-1:0] sync_r;

  genvar gi;
  generate
    for (gi = 0; gi < `HTS_IN_COUNT; gi++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= pins.rawPins[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  assign pins.syncPins = sync_r;
endmodule : hts_input_sync

// ==== hdl/hts_sequencer.sv ====
// Hipot test sequencer top
// Function
// RULE_01: Arc/fault input, total-current trip or gated ground fail sets the fail latch.
// RULE_02: A bad ground counts as a failure only while a test is running.
// RULE_03: A start request needs the start press while the ground check reads good.
// RULE_04: Start is passed on only with no failure latched and no test running.
// RULE_05: The timed test begins at a mains zero crossing after a start, with no failure.
// RULE_06: The timer ends a test that no reset or failure aborts, and it is cleared when the fail latch sets.
// RULE_07: Operator reset clears the test timer and the fail latch.
// RULE_08: Operator reset or a new failure aborts a running test at once.
// RULE_09: The failure warning stays until the operator resets it.
// RULE_10: The ground-ok output is low while the ground loop is within its trip value.
// RULE_11: Ready lamp and start are enabled only while the ground loop is good.
// RULE_12: The alarm output is low while the fail latch is set.
// RULE_13: Two parallel testing outputs are low for the whole test.
// RULE_14: Ground-ok, testing and alarm each also drive a lamp.
// RULE_15: The HV stage raises the arc/fault input on arcing or real-current failure.
// RULE_16: Too little current in a test fails for about one second, then fully resets; the code keeps the latch if start is pressed during the hold.
// RULE_17: All pins are synchronised, and a fail set beats a start in the same cycle.
`timescale 1ns/1ps
`include "hts_params.svh"
module hts_sequencer
  import hts_pkg::*;
#(
  parameter int TICK_CYCLES = `HTS_CLK_MHZ * `HTS_TICK_US
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Operator buttons and analog comparator pins
  input  wire logic        startBtn,
  input  wire logic        resetBtn,
  input  wire logic        arcOrFaultInput,
  input  wire logic        totalCurrentTrip,
  input  wire logic        groundBad,
  input  wire logic        zeroCross,
  input  wire logic        currentPresent,
  // Active-low drive outputs
  output logic             groundTestN,
  output logic             testingAN,
  output logic             testingBN,
  output logic             alarmN,
  // Lamps
  output logic             groundLamp,
  output logic             readyLamp,
  output logic             testingLamp,
  output logic             alarmLamp,
  // Interrupt
  output logic             irq,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

  ////////////////////////////////////////////////
  // Pin synchronisation
  hts_pin_if pinBus ();

  assign pinBus.rawPins = {currentPresent, zeroCross, groundBad, totalCurrentTrip,
                           arcOrFaultInput, resetBtn, startBtn};

  hts_input_sync u_sync ( // RULE_17
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pins    (pinBus.syncer)
  );

  logic     startS;
  logic     resetS;
  logic     arcS;
  logic     totalS;
  logic     gndBadS;
  logic     zcS;
  logic     currentS;
  logic     startPrev_r;
  logic     zcPrev_r;
  logic     groundOk;
  logic     startReq;
  logic     zcEdge;

  assign startS   = pinBus.syncPins[`HTS_IN_START];
  assign resetS   = pinBus.syncPins[`HTS_IN_RESET];
  assign arcS     = pinBus.syncPins[`HTS_IN_ARC];
  assign totalS   = pinBus.syncPins[`HTS_IN_TOTAL];
  assign gndBadS  = pinBus.syncPins[`HTS_IN_GNDBAD];
  assign zcS      = pinBus.syncPins[`HTS_IN_ZC];
  assign currentS = pinBus.syncPins[`HTS_IN_CURRENT];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      startPrev_r <= 1'b0;
      zcPrev_r    <= 1'b0;
    end else begin
      startPrev_r <= startS;
      zcPrev_r    <= zcS;
    end
  end

  assign groundOk = ~gndBadS;
  // Press edge only counts while the ground loop is good
  assign startReq = startS & ~startPrev_r & groundOk; // RULE_03 RULE_11
  // Both edges of the squared mains signal are zero crossings
  assign zcEdge   = zcS ^ zcPrev_r;

  ////////////////////////////////////////////////
  // Millisecond tick divider
  logic [16:0] tickCnt_r;
  logic        msTick;

  assign msTick = (tickCnt_r == TICK_LAST);

  always_ff @(posedge mclk) begin
    if (sys_rst || msTick) begin
      tickCnt_r <= 17'h00000;
    end else begin
      tickCnt_r <= tickCnt_r + 17'h00001;
    end
  end

  ////////////////////////////////////////////////
  // Registers written by software
  logic        swReset_r;
  logic        ucEnable_r;
  hts_ms_t     testTime_r;
  hts_ms_t     ucWin_r;
  logic [2:0]  irqStat_r;
  logic [2:0]  irqMask_r;

  ////////////////////////////////////////////////
  // Sequencer
  hts_seq_e    seq_r;
  hts_seq_e    seq_nxt;
  hts_ms_t     testMs_r;
  hts_ms_t     holdMs_r;
  logic        currentSeen_r;
  logic        underOnly_r;
  logic        restartSeen_r;
  logic [3:0]  cause_r;
  logic        inTest;
  logic        gndFail;
  logic        underFail;
  logic        failNow;
  logic        clearReq;
  logic        testDone;
  logic        autoRelease;
  logic        evStart;
  logic        evFail;
  logic        evDone;

  assign inTest    = (seq_r == SEQ_TEST);
  assign gndFail   = gndBadS & inTest; // RULE_02
  assign underFail = ucEnable_r & inTest & ~currentSeen_r & (testMs_r >= ucWin_r); // RULE_16
  assign failNow   = arcS | totalS | gndFail | underFail; // RULE_01 RULE_15
  assign clearReq  = resetS | swReset_r;
  assign testDone  = inTest & (testMs_r >= testTime_r); // RULE_06
  // Under-current fail self-clears after the hold unless restarted
  assign autoRelease = underOnly_r & (holdMs_r >= `HTS_HOLD_MS) & ~restartSeen_r; // RULE_16

  always_comb begin
    seq_nxt = seq_r;
    unique case (seq_r)
      SEQ_IDLE: begin
        // Fail first: it beats a start
        if (failNow) begin
          seq_nxt = SEQ_FAIL; // RULE_17
        end else if (startReq && !clearReq) begin
          seq_nxt = SEQ_ARMED; // RULE_04
        end
      end
      SEQ_ARMED: begin
        if (failNow) begin
          seq_nxt = SEQ_FAIL;
        end else if (clearReq) begin
          seq_nxt = SEQ_IDLE;
        end else if (zcEdge) begin
          seq_nxt = SEQ_TEST; // RULE_05
        end
      end
      SEQ_TEST: begin
        if (failNow) begin
          seq_nxt = SEQ_FAIL; // RULE_08
        end else if (clearReq) begin
          seq_nxt = SEQ_IDLE; // RULE_08
        end else if (testDone) begin
          seq_nxt = SEQ_IDLE; // RULE_06
        end
      end
      SEQ_FAIL: begin
        // A live cause holds the latch through a reset
        if (!failNow && (clearReq || autoRelease)) begin
          seq_nxt = SEQ_IDLE; // RULE_07 RULE_09
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seq_r <= SEQ_IDLE;
    end else begin
      seq_r <= seq_nxt;
    end
  end

  // Test timer: cleared at start, by reset and whenever the latch sets
  always_ff @(posedge mclk) begin
    if (sys_rst || clearReq || failNow || seq_r != SEQ_TEST) begin
      testMs_r <= 16'h0000; // RULE_06 RULE_07
    end else if (msTick) begin
      testMs_r <= testMs_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || seq_r != SEQ_TEST) begin
      currentSeen_r <= 1'b0;
    end else if (currentS) begin
      currentSeen_r <= 1'b1;
    end
  end

  // Under-current hold timer and cause bookkeeping
  always_ff @(posedge mclk) begin
    if (sys_rst || seq_r != SEQ_FAIL) begin
      holdMs_r <= 16'h0000;
    end else if (msTick && holdMs_r < `HTS_HOLD_MS) begin
      holdMs_r <= holdMs_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      underOnly_r   <= 1'b0;
      restartSeen_r <= 1'b0;
    end else if (seq_r != SEQ_FAIL) begin
      underOnly_r   <= underFail & ~(arcS | totalS | gndFail);
      restartSeen_r <= 1'b0;
    end else begin
      if (arcS || totalS) begin
        underOnly_r <= 1'b0;
      end
      if (startS && !startPrev_r) begin
        restartSeen_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cause_r <= 4'h0;
    end else if (failNow) begin
      cause_r <= cause_r | {underFail, gndFail, totalS, arcS};
    end else if (seq_nxt == SEQ_IDLE && seq_r == SEQ_FAIL) begin
      cause_r <= 4'h0;
    end
  end

  ////////////////////////////////////////////////
  // Pin outputs and lamps
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      groundTestN <= 1'b1;
      testingAN   <= 1'b1;
      testingBN   <= 1'b1;
      alarmN      <= 1'b1;
      groundLamp  <= 1'b0;
      readyLamp   <= 1'b0;
      testingLamp <= 1'b0;
      alarmLamp   <= 1'b0;
    end else begin
      groundTestN <= ~groundOk; // RULE_10
      testingAN   <= ~(seq_nxt == SEQ_TEST); // RULE_13
      testingBN   <= ~(seq_nxt == SEQ_TEST); // RULE_13
      alarmN      <= ~(seq_nxt == SEQ_FAIL); // RULE_12 RULE_09
      groundLamp  <= groundOk; // RULE_14
      readyLamp   <= groundOk & (seq_nxt == SEQ_IDLE); // RULE_11
      testingLamp <= (seq_nxt == SEQ_TEST); // RULE_14
      alarmLamp   <= (seq_nxt == SEQ_FAIL); // RULE_14
    end
  end

  ////////////////////////////////////////////////
  // Interrupts
  logic [2:0] irqEv;

  assign evStart = (seq_r == SEQ_ARMED) & (seq_nxt == SEQ_TEST);
  assign evFail  = failNow & (seq_r != SEQ_FAIL);
  assign evDone  = inTest & (seq_nxt == SEQ_IDLE) & testDone & ~clearReq;
  assign irqEv   = {evDone, evFail, evStart};
  assign irq     = |(irqStat_r & irqMask_r);

  ////////////////////////////////////////////////
  // AXI4-Lite slave
  logic [7:0]  awAddr_r;
  logic        awHave_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        wHave_r;
  logic        doWrite;
  logic        wrHit;
  logic [31:0] rdMux;
  logic        rdHit;

  assign s_axi_awready = ~awHave_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHave_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign doWrite       = awHave_r & wHave_r & ~s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      awHave_r <= 1'b0;
      awAddr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHave_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (doWrite) begin
      awHave_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wHave_r <= 1'b0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHave_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end else if (doWrite) begin
      wHave_r <= 1'b0;
    end
  end

  always_comb begin
    unique case ({awAddr_r[7:2], 2'h0})
      `HTS_ADDR_CTRL, `HTS_ADDR_TESTTIME, `HTS_ADDR_UCWIN, `HTS_ADDR_STATUS,
      `HTS_ADDR_IRQSTAT, `HTS_ADDR_IRQMASK, `HTS_ADDR_ELAPSED: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `HTS_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrHit ? `HTS_RESP_OKAY : `HTS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; software reset is a one-cycle pulse
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      swReset_r  <= 1'b0;
      ucEnable_r <= 1'(`HTS_CTRL_RST >> `HTS_CTRL_UCEN);
      testTime_r <= `HTS_TESTTIME_RST;
      ucWin_r    <= `HTS_UCWIN_RST;
      irqMask_r  <= 3'h0;
    end else begin
      swReset_r <= 1'b0;
      if (doWrite && wStrb_r[0]) begin
        unique case ({awAddr_r[7:2], 2'h0})
          `HTS_ADDR_CTRL: begin
            swReset_r  <= wData_r[`HTS_CTRL_SWRESET];
            ucEnable_r <= wData_r[`HTS_CTRL_UCEN];
          end
          `HTS_ADDR_IRQMASK: irqMask_r <= wData_r[`HTS_IRQ_BITS-1:0];
          default: ;
        endcase
      end
      if (doWrite && {awAddr_r[7:2], 2'h0} == `HTS_ADDR_TESTTIME) begin
        if (wStrb_r[0]) testTime_r[7:0]  <= wData_r[7:0];
        if (wStrb_r[1]) testTime_r[15:8] <= wData_r[15:8];
      end
      if (doWrite && {awAddr_r[7:2], 2'h0} == `HTS_ADDR_UCWIN) begin
        if (wStrb_r[0]) ucWin_r[7:0]  <= wData_r[7:0];
        if (wStrb_r[1]) ucWin_r[15:8] <= wData_r[15:8];
      end
    end
  end

  // Sticky status: set beats a same-cycle write-one clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irqStat_r <= 3'h0;
    end else if (doWrite && wStrb_r[0] && {awAddr_r[7:2], 2'h0} == `HTS_ADDR_IRQSTAT) begin
      irqStat_r <= (irqStat_r & ~wData_r[`HTS_IRQ_BITS-1:0]) | irqEv;
    end else begin
      irqStat_r <= irqStat_r | irqEv;
    end
  end

  always_comb begin
    rdMux = 32'h00000000;
    rdHit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'h0})
      `HTS_ADDR_CTRL:     rdMux[`HTS_CTRL_UCEN] = ucEnable_r;
      `HTS_ADDR_TESTTIME: rdMux[15:0] = testTime_r;
      `HTS_ADDR_UCWIN:    rdMux[15:0] = ucWin_r;
      `HTS_ADDR_STATUS: begin
        rdMux[`HTS_ST_TESTING] = inTest;
        rdMux[`HTS_ST_FAIL]    = (seq_r == SEQ_FAIL);
        rdMux[`HTS_ST_GNDOK]   = groundOk;
        rdMux[`HTS_ST_ARMED]   = (seq_r == SEQ_ARMED);
        rdMux[`HTS_ST_CAUSE_LSB+:4] = cause_r;
      end
      `HTS_ADDR_IRQSTAT:  rdMux[`HTS_IRQ_BITS-1:0] = irqStat_r;
      `HTS_ADDR_IRQMASK:  rdMux[`HTS_IRQ_BITS-1:0] = irqMask_r;
      `HTS_ADDR_ELAPSED:  rdMux[15:0] = testMs_r;
      default:            rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `HTS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= rdHit ? `HTS_RESP_OKAY : `HTS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : hts_sequencer

// ==== verif/hts_seq_asserts.sv ====
// Concurrent checks on the sequencer top-level pins
`timescale 1ns/1ps
module hts_seq_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Pins
  input wire logic resetBtn,
  input wire logic arcOrFaultInput,
  input wire logic totalCurrentTrip,
  input wire logic groundBad,
  input wire logic zeroCross,
  // Drives and lamps
  input wire logic groundTestN,
  input wire logic testingAN,
  input wire logic testingBN,
  input wire logic alarmN,
  input wire logic groundLamp,
  input wire logic readyLamp,
  input wire logic testingLamp,
  input wire logic alarmLamp
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////
  // Cycles since mains edge, saturating
  logic [3:0] zcAge;
  logic       zcPrev;
  always_ff @(posedge mclk) begin
    zcPrev <= zeroCross;
    if (sys_rst) zcAge <= 4'hF;
    else if (zeroCross != zcPrev) zcAge <= 4'h0;
    else if (zcAge != 4'hF) zcAge <= zcAge + 4'h1;
  end
  ////////////////////////////////////////////////
  sequence arcHeld;
    arcOrFaultInput [*4];
  endsequence
  sequence rstHeld;
    resetBtn [*6];
  endsequence
  sequence rstQuiet;
    (resetBtn && !arcOrFaultInput && !totalCurrentTrip) [*6];
  endsequence
  AST_TEST_PAIR: assert property (testingAN == testingBN)
    else $error("test pair");
  AST_TEST_LAMP: assert property (testingLamp != testingAN)
    else $error("test lamp");
  AST_ALARM_LAMP: assert property (alarmLamp != alarmN)
    else $error("alarm lamp");
  AST_GND_LAMP: assert property (groundLamp != groundTestN)
    else $error("gnd lamp");
  AST_GND_BAD: assert property (groundBad [*5] |-> groundTestN)
    else $error("gnd bad");
  AST_GND_GOOD: assert property (!groundBad [*5] |-> !groundTestN)
    else $error("gnd good");
  AST_READY: assert property (readyLamp |-> groundLamp)
    else $error("ready");
  AST_EXCL: assert property (!(testingLamp && alarmLamp))
    else $error("test and fail");
  AST_ARC: assert property (arcHeld |-> ##[0:4] alarmLamp)
    else $error("arc no fail");
  AST_ZC: assert property ($fell(testingAN) |-> zcAge inside {[1:8]})
    else $error("start off zc");
  AST_RST_ABORT: assert property (rstHeld |-> !testingLamp)
    else $error("no abort");
  AST_RST_CLR: assert property (rstQuiet |-> !alarmLamp)
    else $error("no clear");
endmodule : hts_seq_asserts

bind hts_sequencer hts_seq_asserts u_chk (.mclk, .sys_rst, .resetBtn, .arcOrFaultInput,
  .totalCurrentTrip, .groundBad, .zeroCross, .groundTestN, .testingAN, .testingBN,
  .alarmN, .groundLamp, .readyLamp, .testingLamp, .alarmLamp);

// ==== verif/hts_panel_model.sv ====
// Panel model: mains square wave, HV fault line
`timescale 1ns/1ps
module hts_panel_model #(
  parameter int ZC_HALF = 20
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Events commanded by the bench
  input wire logic arcEvent,
  input wire logic realFail,
  // Pins into the sequencer
  output logic     arcOrFaultInput,
  output logic     zeroCross
);
  int   cnt = 0;
  logic zcR = 1'b0;
  logic arcR = 1'b0;
  assign zeroCross = zcR;
  assign arcOrFaultInput = arcR;
  // Mains runs on through reset, as the real line does
  always_ff @(posedge mclk) begin
    cnt <= (cnt == ZC_HALF - 1) ? 0 : cnt + 1;
    if (cnt == ZC_HALF - 1) zcR <= !zcR;
  end
  always_ff @(posedge mclk) begin
    arcR <= !sys_rst && (arcEvent || realFail);
  end
endmodule : hts_panel_model

// ==== verif/testbench.sv ====
// Self-checking bench of the hipot test sequencer
`timescale 1ns/1ps
`include "hts_params.svh"
module testbench;
  import hts_pkg::*;
  localparam int TICK = 10;
  localparam logic [7:0] RA [6] = '{`HTS_ADDR_CTRL, `HTS_ADDR_TESTTIME, `HTS_ADDR_UCWIN,
                                    `HTS_ADDR_IRQSTAT, `HTS_ADDR_IRQMASK, 8'h1C};
  localparam logic [31:0] RV [6] = '{{30'h0, `HTS_CTRL_RST}, {16'h0, `HTS_TESTTIME_RST},
                                     {16'h0, `HTS_UCWIN_RST}, 32'h0, 32'h0, 32'h0};
  localparam logic [3:0] CB [5] = '{4'h1, 4'h2, 4'h4, 4'h1, 4'h8};
  logic mclk = 1'b0, sys_rst = 1'b1, startBtn = 1'b0, resetBtn = 1'b0;
  logic totalCurrentTrip = 1'b0, groundBad = 1'b0, currentPresent = 1'b1;
  logic arcEvent = 1'b0, realFail = 1'b0, arcOrFaultInput, zeroCross;
  logic groundTestN, testingAN, testingBN, alarmN, groundLamp, readyLamp;
  logic testingLamp, alarmLamp, irq, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h93E3;
  logic [1:0]  bresp, rresp;
  int          n_fail = 0, checks_done = 0;
  initial forever #5 mclk = ~mclk;
  hts_sequencer #(.TICK_CYCLES(TICK)) dut (.mclk, .sys_rst, .startBtn, .resetBtn,
    .arcOrFaultInput, .totalCurrentTrip, .groundBad, .zeroCross, .currentPresent,
    .groundTestN, .testingAN, .testingBN, .alarmN, .groundLamp, .readyLamp, .testingLamp,
    .alarmLamp, .irq,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  hts_panel_model u_panel (.mclk, .sys_rst, .arcEvent, .realFail, .arcOrFaultInput,
    .zeroCross);
  ////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic logic [31:0] expStatus(input int k);
    return 32'h2 | ((k == 2) ? 32'h0 : 32'h4) | {24'h0, CB[k], 4'h0};
  endfunction : expStatus
  // Free tick phase: up to one ms early
  function automatic logic durOk(input int dur, input int t);
    return (dur >= (t - 1) * TICK) && (dur <= t * TICK + 6);
  endfunction : durOk
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %0t: %s seen %0h exp %0h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic hang(input string msg);
    check(32'h0, 32'h1, msg);
    print_verdict();
  endtask : hang
  task automatic waitFor(ref logic s, input logic v, input int lim, output int used);
    used = 0;
    do begin
      @(negedge mclk);
      used++;
    end while (s !== v && used < lim);
    if (s !== v) hang("wait ran out");
  endtask : waitFor
  ////////////////////////////////////////////////
  // Ready sampled mid-cycle; the next edge takes
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic [1:0] er);
    logic aT, wT, arT, rT;
    logic [31:0] q;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge mclk);
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    do begin
      @(negedge mclk);
      aT = awvalid && awready;
      wT = wvalid && wready;
      arT = arvalid && arready;
      rT = w ? bvalid : rvalid;
      q = rdata;
      r = w ? bresp : rresp;
      n++;
      if (n > 100) hang("bus hang");
      @(posedge mclk);
      if (aT) awvalid <= 1'b0;
      if (wT) wvalid <= 1'b0;
      if (arT) arvalid <= 1'b0;
      if (rT) bready <= 1'b0;
      if (rT) rready <= 1'b0;
    end while (!rT);
    check(r, er, "response");
    if (!w) check(q, ed, "read data");
  endtask : axi
  task automatic pulse(input logic s);
    @(posedge mclk);
    if (s) startBtn <= 1'b1;
    else resetBtn <= 1'b1;
    repeat (6) @(posedge mclk);
    startBtn <= 1'b0;
    resetBtn <= 1'b0;
  endtask : pulse
  task automatic setCause(input int k, input logic v);
    @(posedge mclk);
    case (k)
      0: arcEvent <= v;
      1: totalCurrentTrip <= v;
      2: groundBad <= v;
      3: realFail <= v;
      default: currentPresent <= !v;
    endcase
  endtask : setCause
  ////////////////////////////////////////////////
  initial begin
    int t, used;
    repeat (11) @(posedge mclk);
    @(negedge mclk);
    check(testingAN, 1'b1, "rst tst");
    check(alarmLamp, 1'b0, "rst alm");
    check(irq, 1'b0, "rst irq");
    @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) axi(1'b0, RA[i], 0, RV[i], (i == 5) ? 2'h2 : 2'h0);
    axi(1'b1, 8'h20, 32'h1, 0, 2'h2);
    axi(1'b1, `HTS_ADDR_IRQMASK, 32'h7, 0, 2'h0);
    axi(1'b1, `HTS_ADDR_UCWIN, 32'h2, 0, 2'h0);
    $display("test registers done");
    setCause(2, 1'b1);
    repeat (40) @(negedge mclk);
    check(readyLamp, 1'b0, "rdy bad gnd");
    check(alarmLamp, 1'b0, "idle gnd");
    pulse(1'b1);
    repeat (60) @(negedge mclk);
    check(testingLamp, 1'b0, "start bad gnd");
    setCause(2, 1'b0);
    repeat (6) @(negedge mclk);
    check(readyLamp, 1'b1, "rdy");
    $display("test ground done");
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      t = 4 + int'(seed % 8);
      axi(1'b1, `HTS_ADDR_TESTTIME, t, 0, 2'h0);
      pulse(1'b1);
      waitFor(testingLamp, 1'b1, 100, used);
      check(testingBN, 1'b0, "tst B");
      waitFor(testingLamp, 1'b0, t * TICK + 50, used);
      check(durOk(used, t), 1'b1, "length");
      axi(1'b0, `HTS_ADDR_IRQSTAT, 0, 32'h5, 2'h0);
      check(irq, 1'b1, "irq set");
      axi(1'b1, `HTS_ADDR_IRQSTAT, 32'h7, 0, 2'h0);
      @(negedge mclk);
      check(irq, 1'b0, "irq clr");
    end
    $display("test timed runs done");
    for (int k = 0; k < 5; k++) begin
      // No current from the start, so the window check can trip
      if (k == 4) setCause(k, 1'b1);
      pulse(1'b1);
      waitFor(testingLamp, 1'b1, 100, used);
      if (k != 4) setCause(k, 1'b1);
      waitFor(alarmLamp, 1'b1, 3 * TICK + 40, used);
      check(testingLamp, 1'b0, "abort");
      check(alarmN, 1'b0, "alarmN");
      axi(1'b0, `HTS_ADDR_STATUS, 0, expStatus(k), 2'h0);
      axi(1'b1, `HTS_ADDR_IRQMASK, 32'h4, 0, 2'h0);
      @(negedge mclk);
      check(irq, 1'b0, "irq mask");
      axi(1'b1, `HTS_ADDR_IRQMASK, 32'h7, 0, 2'h0);
      if (k == 4) begin
        waitFor(alarmLamp, 1'b0, `HTS_HOLD_MS * TICK + 50, used);
        check(used >= (`HTS_HOLD_MS - 1) * TICK, 1'b1, "hold");
        setCause(k, 1'b0);
      end else begin
        pulse(1'b0);
        pulse(1'b1);
        repeat (50) @(negedge mclk);
        // Bad ground is no cause outside a test, so reset clears it
        check(alarmLamp, k != 2, "rst busy");
        check(testingLamp, 1'b0, "start failed");
        setCause(k, 1'b0);
        repeat (30) @(negedge mclk);
        check(alarmLamp, k != 2, "stays");
        pulse(1'b0);
        repeat (4) @(negedge mclk);
        check(alarmLamp, 1'b0, "rst clr");
      end
      axi(1'b0, `HTS_ADDR_IRQSTAT, 0, 32'h3, 2'h0);
      axi(1'b1, `HTS_ADDR_IRQSTAT, 32'h7, 0, 2'h0);
    end
    $display("test faults done");
    for (int j = 0; j < 2; j++) begin
      pulse(1'b1);
      waitFor(testingLamp, 1'b1, 100, used);
      if (j == 0) pulse(1'b0);
      else axi(1'b1, `HTS_ADDR_CTRL, 32'h3, 0, 2'h0);
      waitFor(testingLamp, 1'b0, 20, used);
      check(alarmLamp, 1'b0, "abort fail");
    end
    $display("test aborts done");
    print_verdict();
  end
endmodule : testbench
